// *** rtl/bla_pkg.sv ***
// package of the byte logic / compare / increment execution group
// assumes an apb3 master on pclk and software that supplies the memory byte
// How it works
// - or: accumulator gets accumulator or operand
// - f6 plus immediate is or-immediate; b6 is or with pointer_pair byte
// - or flags: s and z from result; h, n, c cleared; p/v cleared
// - xor: accumulator gets accumulator xor operand
// - ee plus immediate is xor-immediate; ae is xor with pointer_pair byte
// - xor flags: p/v on even parity; h, n, c cleared; s, z from result
// - compare_instr subtracts only for flags; accumulator kept
// - fe plus immediate compares immediate; be compares pointer_pair byte
// - compare flags: z equal, n set, c borrow, h nibble borrow, v, s
// - prefix dd or fd picks index register; opcode then signed displacement
// - register codes 000 to 101 general registers; 111 the accumulator
// - register increment adds one and writes back to that register
// - increment flags: h nibble carry, n cleared, c kept, v on 7f
// - opcode 34 increments the pointer_pair memory byte in place
// - memory increment: v exactly on fetched 7f; c kept
package bla_pkg;
    // ****************
    // register map
    // ****************
    localparam logic [7:0] OFF_INSTR = 8'h00;
    localparam logic [7:0] OFF_GPR_LO = 8'h04;
    localparam logic [7:0] OFF_GPR_HI = 8'h08;
    localparam logic [7:0] OFF_FLAGS = 8'h0c;
    localparam logic [7:0] OFF_MEM = 8'h10;
    localparam logic [7:0] OFF_INDEX = 8'h14;
    localparam logic [7:0] OFF_STATUS = 8'h18;
    // ****************
    // opcodes and codes
    // ****************
    localparam logic [7:0] OP_OR_IMM = 8'hf6;
    localparam logic [7:0] OP_XOR_IMM = 8'hee;
    localparam logic [7:0] OP_CMP_IMM = 8'hfe;
    localparam logic [7:0] OP_PFX_FIRST = 8'hdd;
    localparam logic [7:0] OP_PFX_SECOND = 8'hfd;
    localparam logic [1:0] GRP_ALU = 2'h2;
    localparam logic [1:0] GRP_IMM = 2'h3;
    localparam logic [1:0] GRP_INC = 2'h0;
    localparam logic [2:0] LOW_INC = 3'h4;
    localparam logic [2:0] LOW_IMM = 3'h6;
    localparam logic [2:0] FN_OR = 3'h6;
    localparam logic [2:0] FN_XOR = 3'h5;
    localparam logic [2:0] FN_CMP = 3'h7;
    localparam logic [2:0] RC_MEM = 3'h6;
    localparam logic [2:0] RC_ACC = 3'h7;
    localparam logic [2:0] RC_H = 3'h4;
    localparam logic [2:0] RC_L = 3'h5;
    localparam logic [7:0] INC_OVF_VAL = 8'h7f;
    localparam logic [3:0] NIB_FULL = 4'hf;
    // ****************
    // flag positions
    // ****************
    localparam int F_S = 7;
    localparam int F_Z = 6;
    localparam int F_H = 4;
    localparam int F_V = 2;
    localparam int F_N = 1;
    localparam int F_C = 0;

    typedef struct packed {
        logic pready;
        logic pslverr;
        logic [31:0] prdata;
        logic [23:0] instr;
        logic go;
        logic [7:0][7:0] gpr;
        logic [7:0] flags;
        logic [7:0] mem;
        logic [15:0] ix;
        logic [15:0] iy;
        logic illegal;
        logic mem_rd;
        logic mem_wr;
        logic [15:0] addr;
    } bla_state_t;
endpackage : bla_pkg

// *** rtl/bla_core.sv ***
// execution group: or, xor, compare and increment over an apb3 register file
// assumes software loads operands, the memory byte and the instruction bytes
//
// Our own choices: the address map and the APB interface to the registers.
`timescale 1ns/1ps
module bla_core (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // apb3 slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr
);
    bla_pkg::bla_state_t q;
    bla_pkg::bla_state_t d;

    // ****************
    // decode
    // ****************
    logic [7:0] b0, b1, b2, op, src, res, acc;
    logic pfx, is_alu, is_imm, is_inc, bad;
    logic [2:0] fn, rc;
    logic [8:0] diff;
    logic [15:0] eaddr;

    assign b0 = q.instr[7:0];
    assign b1 = q.instr[15:8];
    assign b2 = q.instr[23:16];
    assign acc = q.gpr[bla_pkg::RC_ACC];
    assign pfx = (b0 == bla_pkg::OP_PFX_FIRST) || (b0 == bla_pkg::OP_PFX_SECOND);
    assign op = pfx ? b1 : b0;
    assign fn = op[5:3];
    assign is_imm = !pfx && (op == bla_pkg::OP_OR_IMM || op == bla_pkg::OP_XOR_IMM
        || op == bla_pkg::OP_CMP_IMM);
    assign is_alu = op[7:6] == bla_pkg::GRP_ALU
        && (fn == bla_pkg::FN_OR || fn == bla_pkg::FN_XOR || fn == bla_pkg::FN_CMP);
    assign is_inc = op[7:6] == bla_pkg::GRP_INC && op[2:0] == bla_pkg::LOW_INC;
    assign rc = is_inc ? op[5:3] : op[2:0];
    // index forms only for the memory-operand or, xor and compare; indexed increment is not served
    assign bad = !(is_imm || is_alu || is_inc) || (pfx && !(is_alu && rc == bla_pkg::RC_MEM));
    // d sign-extended onto the chosen index register
    assign eaddr = !pfx ? {q.gpr[bla_pkg::RC_H], q.gpr[bla_pkg::RC_L]}
        : (b0 == bla_pkg::OP_PFX_SECOND ? q.iy : q.ix) + {{8{b2[7]}}, b2};
    assign src = is_imm ? b1 : (rc == bla_pkg::RC_MEM ? q.mem : q.gpr[rc]);
    assign diff = {1'b0, acc} - {1'b0, src};

    always_comb begin
        d = q;
        d.go = 1'b0;
        res = 8'h00;
        // ****************
        // apb slave
        // ****************
        d.pready = psel && penable && !q.pready;
        d.pslverr = 1'b0;
        if (psel && penable && !q.pready) begin
            d.prdata = 32'h0000_0000;
            case (paddr)
                bla_pkg::OFF_INSTR: d.prdata = {8'h00, q.instr};
                bla_pkg::OFF_GPR_LO: d.prdata = {q.gpr[3], q.gpr[2], q.gpr[1], q.gpr[0]};
                bla_pkg::OFF_GPR_HI: d.prdata = {q.gpr[7], 8'h00, q.gpr[5], q.gpr[4]};
                bla_pkg::OFF_FLAGS: d.prdata = {24'h000000, q.flags};
                bla_pkg::OFF_MEM: d.prdata = {24'h000000, q.mem};
                bla_pkg::OFF_INDEX: d.prdata = {q.iy, q.ix};
                bla_pkg::OFF_STATUS: d.prdata = {q.addr, 13'h0000, q.mem_wr, q.mem_rd, q.illegal};
                default: d.pslverr = 1'b1;
            endcase
        end
        if (psel && penable && q.pready && pwrite) begin
            case (paddr)
                bla_pkg::OFF_INSTR: begin
                    d.instr = pwdata[23:0];
                    d.go = 1'b1;
                end
                bla_pkg::OFF_GPR_LO: begin
                    d.gpr[0] = pwdata[7:0];
                    d.gpr[1] = pwdata[15:8];
                    d.gpr[2] = pwdata[23:16];
                    d.gpr[3] = pwdata[31:24];
                end
                bla_pkg::OFF_GPR_HI: begin
                    d.gpr[4] = pwdata[7:0];
                    d.gpr[5] = pwdata[15:8];
                    d.gpr[7] = pwdata[31:24];
                end
                bla_pkg::OFF_FLAGS: d.flags = pwdata[7:0];
                bla_pkg::OFF_MEM: d.mem = pwdata[7:0];
                bla_pkg::OFF_INDEX: begin
                    d.ix = pwdata[15:0];
                    d.iy = pwdata[31:16];
                end
                default: d.flags = q.flags;
            endcase
        end
        // ****************
        // execute, one cycle after the instruction write
        // ****************
        if (q.go) begin
            d.illegal = bad;
            d.mem_rd = !bad && !is_imm && rc == bla_pkg::RC_MEM;
            d.mem_wr = !bad && is_inc && rc == bla_pkg::RC_MEM;
            d.addr = eaddr;
            if (!bad && is_inc) begin
                res = src + 8'h01;
                if (rc == bla_pkg::RC_MEM) begin
                    d.mem = res;
                end else begin
                    d.gpr[rc] = res;
                end
                d.flags[bla_pkg::F_S] = res[7];
                d.flags[bla_pkg::F_Z] = res == 8'h00;
                d.flags[bla_pkg::F_H] = src[3:0] == bla_pkg::NIB_FULL;
                d.flags[bla_pkg::F_V] = src == bla_pkg::INC_OVF_VAL;
                d.flags[bla_pkg::F_N] = 1'b0;
            end else if (!bad) begin
                case (fn)
                    bla_pkg::FN_OR: begin
                        res = acc | src;
                        d.gpr[bla_pkg::RC_ACC] = res;
                        d.flags[bla_pkg::F_V] = 1'b0;
                    end
                    bla_pkg::FN_XOR: begin
                        res = acc ^ src;
                        d.gpr[bla_pkg::RC_ACC] = res;
                        d.flags[bla_pkg::F_V] = ~^res;
                    end
                    default: begin
                        res = diff[7:0];
                        d.flags[bla_pkg::F_V] = (acc[7] != src[7]) && (res[7] != acc[7]);
                    end
                endcase
                d.flags[bla_pkg::F_S] = res[7];
                d.flags[bla_pkg::F_Z] = res == 8'h00;
                d.flags[bla_pkg::F_H] = fn == bla_pkg::FN_CMP && acc[3:0] < src[3:0];
                d.flags[bla_pkg::F_N] = fn == bla_pkg::FN_CMP;
                d.flags[bla_pkg::F_C] = fn == bla_pkg::FN_CMP && diff[8];
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    assign prdata = q.prdata;
    assign pready = q.pready;
    assign pslverr = q.pslverr;

    // ****************
    // checks
    // ****************
    logic [7:0] q_acc;
    assign q_acc = q.gpr[bla_pkg::RC_ACC];

    property p_or_acc;
        @(posedge pclk) disable iff (!presetn)
        q.go && !bad && !is_inc && fn == bla_pkg::FN_OR |=> q_acc == ($past(acc) | $past(src));
    endproperty
    a_or_acc: assert property (p_or_acc) else $error("or result wrong");
    property p_or_imm;
        @(posedge pclk) disable iff (!presetn)
        q.go && b0 == bla_pkg::OP_OR_IMM |=> q_acc == ($past(acc) | $past(b1)) && !q.illegal;
    endproperty
    a_or_imm: assert property (p_or_imm) else $error("or immediate decode wrong");
    property p_logic_flags;
        @(posedge pclk) disable iff (!presetn)
        q.go && !bad && !is_inc && fn != bla_pkg::FN_CMP
        |=> !q.flags[bla_pkg::F_C] && !q.flags[bla_pkg::F_N] && !q.flags[bla_pkg::F_H]
            && q.flags[bla_pkg::F_Z] == (q_acc == 8'h00) && q.flags[bla_pkg::F_S] == q_acc[7];
    endproperty
    a_logic_flags: assert property (p_logic_flags) else $error("logic flags wrong");
    property p_xor_imm;
        @(posedge pclk) disable iff (!presetn)
        q.go && b0 == bla_pkg::OP_XOR_IMM
        |=> q_acc == ($past(acc) ^ $past(b1)) && q.flags[bla_pkg::F_V] == ~^q_acc;
    endproperty
    a_xor_imm: assert property (p_xor_imm) else $error("xor immediate wrong");
    property p_cmp_keep;
        @(posedge pclk) disable iff (!presetn)
        q.go && !bad && !is_inc && fn == bla_pkg::FN_CMP
        |=> q_acc == $past(acc) && q.flags[bla_pkg::F_N]
            && q.flags[bla_pkg::F_Z] == ($past(acc) == $past(src))
            && q.flags[bla_pkg::F_C] == ($past(acc) < $past(src));
    endproperty
    a_cmp_keep: assert property (p_cmp_keep) else $error("compare wrong");
    property p_index_addr;
        @(posedge pclk) disable iff (!presetn)
        q.go && b0 == bla_pkg::OP_PFX_FIRST && !bad
        |=> q.addr == $past(q.ix) + {{8{$past(b2[7])}}, $past(b2)} && q.mem_rd;
    endproperty
    a_index_addr: assert property (p_index_addr) else $error("indexed address wrong");
    property p_inc_reg;
        @(posedge pclk) disable iff (!presetn)
        q.go && !bad && is_inc && rc != bla_pkg::RC_MEM
        |=> q.gpr[$past(rc)] == $past(src) + 8'h01 && q.flags[bla_pkg::F_C] == $past(q.flags[bla_pkg::F_C])
            && !q.flags[bla_pkg::F_N];
    endproperty
    a_inc_reg: assert property (p_inc_reg) else $error("register increment wrong");
    property p_inc_mem;
        @(posedge pclk) disable iff (!presetn)
        q.go && !bad && is_inc && rc == bla_pkg::RC_MEM
        |=> q.mem == $past(q.mem) + 8'h01 && q.mem_wr
            && q.flags[bla_pkg::F_V] == ($past(q.mem) == bla_pkg::INC_OVF_VAL);
    endproperty
    a_inc_mem: assert property (p_inc_mem) else $error("memory increment wrong");
    property p_apb_ready;
        @(posedge pclk) disable iff (!presetn)
        psel && penable && !pready |=> pready ##1 !pready;
    endproperty
    a_apb_ready: assert property (p_apb_ready) else $error("apb ready timing wrong");

    // ****************
    // operand forms and flag details
    // ****************
    property p_or_mem;
        @(posedge pclk) disable iff (!presetn)
        q.go && !pfx && op == {bla_pkg::GRP_ALU, bla_pkg::FN_OR, bla_pkg::RC_MEM}
        |=> q_acc == ($past(acc) | $past(q.mem)) && q.mem_rd;
    endproperty
    a_or_mem: assert property (p_or_mem) else $error("or memory form wrong");

    property p_or_pv;
        @(posedge pclk) disable iff (!presetn)
        q.go && !bad && !is_inc && fn == bla_pkg::FN_OR |=> !q.flags[bla_pkg::F_V];
    endproperty
    a_or_pv: assert property (p_or_pv) else $error("or parity flag wrong");

    property p_xor_acc;
        @(posedge pclk) disable iff (!presetn)
        q.go && !bad && !is_inc && fn == bla_pkg::FN_XOR |=> q_acc == ($past(acc) ^ $past(src));
    endproperty
    a_xor_acc: assert property (p_xor_acc) else $error("xor result wrong");

    property p_xor_mem;
        @(posedge pclk) disable iff (!presetn)
        q.go && !pfx && op == {bla_pkg::GRP_ALU, bla_pkg::FN_XOR, bla_pkg::RC_MEM}
        |=> q_acc == ($past(acc) ^ $past(q.mem)) && q.mem_rd;
    endproperty
    a_xor_mem: assert property (p_xor_mem) else $error("xor memory form wrong");

    property p_xor_parity;
        @(posedge pclk) disable iff (!presetn)
        q.go && !bad && !is_inc && fn == bla_pkg::FN_XOR |=> q.flags[bla_pkg::F_V] == ~^q_acc;
    endproperty
    a_xor_parity: assert property (p_xor_parity) else $error("xor parity wrong");

    property p_cmp_imm;
        @(posedge pclk) disable iff (!presetn)
        q.go && b0 == bla_pkg::OP_CMP_IMM
        |=> q_acc == $past(acc) && q.flags[bla_pkg::F_Z] == ($past(acc) == $past(b1)) && !q.illegal;
    endproperty
    a_cmp_imm: assert property (p_cmp_imm) else $error("compare immediate wrong");

    property p_cmp_mem;
        @(posedge pclk) disable iff (!presetn)
        q.go && !pfx && op == {bla_pkg::GRP_ALU, bla_pkg::FN_CMP, bla_pkg::RC_MEM}
        |=> q.mem_rd && q.flags[bla_pkg::F_Z] == ($past(acc) == $past(q.mem));
    endproperty
    a_cmp_mem: assert property (p_cmp_mem) else $error("compare memory form wrong");

    property p_cmp_h;
        @(posedge pclk) disable iff (!presetn)
        q.go && !bad && !is_inc && fn == bla_pkg::FN_CMP
        |=> q.flags[bla_pkg::F_H] == ($past(acc[3:0]) < $past(src[3:0]));
    endproperty
    a_cmp_h: assert property (p_cmp_h) else $error("compare nibble borrow wrong");

    property p_cmp_sv;
        @(posedge pclk) disable iff (!presetn)
        q.go && !bad && !is_inc && fn == bla_pkg::FN_CMP
        |=> q.flags[bla_pkg::F_S] == $past(diff[7])
            && q.flags[bla_pkg::F_V] == ($past(acc[7]) != $past(src[7]) && $past(diff[7]) != $past(acc[7]));
    endproperty
    a_cmp_sv: assert property (p_cmp_sv) else $error("compare sign or overflow wrong");

    property p_index_second;
        @(posedge pclk) disable iff (!presetn)
        q.go && b0 == bla_pkg::OP_PFX_SECOND && !bad
        |=> q.addr == $past(q.iy) + {{8{$past(b2[7])}}, $past(b2)} && q.mem_rd;
    endproperty
    a_index_second: assert property (p_index_second) else $error("second index address wrong");

    property p_index_inc_refused;
        @(posedge pclk) disable iff (!presetn)
        q.go && pfx && is_inc |=> q.illegal && !q.mem_wr;
    endproperty
    a_index_inc_refused: assert property (p_index_inc_refused) else $error("indexed increment served");

    property p_illegal_hold;
        @(posedge pclk) disable iff (!presetn)
        q.go && bad
        |=> q.illegal && q.flags == $past(q.flags) && q.gpr == $past(q.gpr) && q.mem == $past(q.mem);
    endproperty
    a_illegal_hold: assert property (p_illegal_hold) else $error("illegal opcode changed state");

    property p_acc_code;
        @(posedge pclk) disable iff (!presetn)
        q.go && !bad && is_inc && rc == bla_pkg::RC_ACC |=> q_acc == $past(acc) + 8'h01;
    endproperty
    a_acc_code: assert property (p_acc_code) else $error("accumulator code wrong");

    property p_inc_h;
        @(posedge pclk) disable iff (!presetn)
        q.go && !bad && is_inc
        |=> q.flags[bla_pkg::F_H] == ($past(src[3:0]) == bla_pkg::NIB_FULL) && !q.flags[bla_pkg::F_N];
    endproperty
    a_inc_h: assert property (p_inc_h) else $error("increment half carry wrong");

    property p_inc_v;
        @(posedge pclk) disable iff (!presetn)
        q.go && !bad && is_inc && rc != bla_pkg::RC_MEM
        |=> q.flags[bla_pkg::F_V] == ($past(src) == bla_pkg::INC_OVF_VAL);
    endproperty
    a_inc_v: assert property (p_inc_v) else $error("increment overflow wrong");

    property p_inc_mem_c;
        @(posedge pclk) disable iff (!presetn)
        q.go && !bad && is_inc && rc == bla_pkg::RC_MEM
        |=> q.flags[bla_pkg::F_C] == $past(q.flags[bla_pkg::F_C])
            && q.addr == $past({q.gpr[bla_pkg::RC_H], q.gpr[bla_pkg::RC_L]});
    endproperty
    a_inc_mem_c: assert property (p_inc_mem_c) else $error("memory increment carry or address wrong");

    property p_inc_opcode;
        @(posedge pclk) disable iff (!presetn)
        q.go && !pfx && op[7:6] == bla_pkg::GRP_INC && op[2:0] == bla_pkg::LOW_INC |=> !q.illegal;
    endproperty
    a_inc_opcode: assert property (p_inc_opcode) else $error("increment opcode refused");

    c_cmp: cover property (@(posedge pclk) disable iff (!presetn) q.go && !bad && fn == bla_pkg::FN_CMP);
    c_inc_mem: cover property (@(posedge pclk) disable iff (!presetn) q.go && !bad && is_inc && rc == bla_pkg::RC_MEM);
    c_index: cover property (@(posedge pclk) disable iff (!presetn) q.go && pfx && !bad);
    c_illegal: cover property (@(posedge pclk) disable iff (!presetn) q.go && bad);
endmodule : bla_core

// *** sim/bla_seq_model.sv ***
// apb3 master standing in for the instruction sequencer
// assumes a slave on pclk that answers with pready
`timescale 1ns/1ps
module bla_seq_model (
    // clock
    input wire logic pclk,
    // apb3 master side
    output logic psel,
    output logic penable,
    output logic pwrite,
    output logic [7:0] paddr,
    output logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr
);
    initial begin
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
    end

    // request held until pready is seen high at a rising edge
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                        output logic [31:0] r, output logic e);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        // released data must not look valid
        pwdata <= ~d;
    endtask : xfer
endmodule : bla_seq_model

// *** sim/test_byte_logic_compare_increment_alu.sv ***
// self-checking bench for the execution group
// assumes bla_core and the sequencer model on one 200 MHz clock
`timescale 1ns/1ps
module test_byte_logic_compare_increment_alu;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel, penable, pwrite, pready, pslverr;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata;
    int error_cnt = 0;
    int total_checks = 0;
    int cyc = 0;

    bla_core i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));
    bla_seq_model i_seq (.pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));

    always #2.5 pclk = ~pclk;

    // ****************
    // helpers
    // ****************
    task automatic summarize;
        $display("checks %0d mismatches %0d", total_checks, error_cnt);
        if (error_cnt == 0 && total_checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : summarize

    // a hang ends the run here
    always @(posedge pclk) begin
        cyc++;
        if (cyc == 5000) begin
            error_cnt++;
            summarize();
        end
    end

    task automatic chk(input logic [31:0] s, input logic [31:0] e);
        total_checks++;
        if (s !== e) begin
            error_cnt++;
            $display("unexpected at %0t: seen %h expected %h", $time, s, e);
        end
    endtask : chk

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] r;
        logic e;
        i_seq.xfer(1'b1, a, d, r, e);
    endtask : wr

    task automatic rd(input logic [7:0] a, output logic [31:0] r);
        logic e;
        i_seq.xfer(1'b0, a, 32'h0, r, e);
    endtask : rd

    task automatic setup(input logic [31:0] lo, input logic [31:0] hi, input logic [7:0] fl,
                         input logic [7:0] m);
        wr(bla_pkg::OFF_GPR_LO, lo);
        wr(bla_pkg::OFF_GPR_HI, hi);
        wr(bla_pkg::OFF_FLAGS, {24'h0, fl});
        wr(bla_pkg::OFF_MEM, {24'h0, m});
    endtask : setup

    // execute, then judge accumulator, flags and memory byte
    task automatic run(input logic [31:0] ins, input logic [7:0] acc, input logic [7:0] fl,
                       input logic [7:0] m);
        logic [31:0] r;
        wr(bla_pkg::OFF_INSTR, ins);
        rd(bla_pkg::OFF_GPR_HI, r);
        chk({24'h0, r[31:24]}, {24'h0, acc});
        rd(bla_pkg::OFF_FLAGS, r);
        chk({24'h0, r[7:0]}, {24'h0, fl});
        rd(bla_pkg::OFF_MEM, r);
        chk({24'h0, r[7:0]}, {24'h0, m});
    endtask : run

    task automatic st(input logic [31:0] e);
        logic [31:0] r;
        rd(bla_pkg::OFF_STATUS, r);
        chk(r, e);
    endtask : st

    // ****************
    // scenarios
    // ****************
    task automatic t_or;
        setup(32'h0, 32'h1200_0048, 8'hff, 8'h00);
        run(32'h0000_00b4, 8'h5a, 8'h28, 8'h00);
        setup(32'h0, 32'h0, 8'hff, 8'h00);
        run(32'h0000_00f6, 8'h00, 8'h68, 8'h00);
        setup(32'h0, 32'h0100_3412, 8'h00, 8'h80);
        run(32'h0000_00b6, 8'h81, 8'h80, 8'h80);
        st(32'h1234_0002);
    endtask : t_or

    task automatic t_xor;
        setup(32'h0, 32'h9600_0000, 8'h00, 8'h00);
        run(32'h0000_5dee, 8'hcb, 8'h80, 8'h00);
        setup(32'h0, 32'hff00_0000, 8'h00, 8'h0f);
        run(32'h0000_00ae, 8'hf0, 8'h84, 8'h0f);
        setup(32'h55, 32'h5500_0000, 8'hff, 8'h00);
        run(32'h0000_00a8, 8'h00, 8'h6c, 8'h00);
    endtask : t_xor

    task automatic t_cmp;
        setup(32'h0, 32'h6300_0000, 8'h00, 8'h60);
        run(32'h0000_00be, 8'h63, 8'h02, 8'h60);
        setup(32'h0, 32'h1000_0000, 8'h00, 8'h00);
        run(32'h0000_21fe, 8'h10, 8'h93, 8'h00);
        setup(32'h0, 32'h8000_0000, 8'h00, 8'h00);
        run(32'h0000_01fe, 8'h80, 8'h16, 8'h00);
        setup(32'h4200_0000, 32'h4200_0000, 8'h00, 8'h00);
        run(32'h0000_00bb, 8'h42, 8'h42, 8'h00);
    endtask : t_cmp

    task automatic t_idx;
        wr(bla_pkg::OFF_INDEX, 32'h2020_1000);
        setup(32'h0, 32'h0100_0000, 8'h00, 8'h02);
        run(32'h00f0_b6dd, 8'h03, 8'h00, 8'h02);
        st(32'h0ff0_0002);
        setup(32'h0, 32'h0500_0000, 8'h00, 8'h05);
        run(32'h0010_befd, 8'h05, 8'h42, 8'h05);
        st(32'h2030_0002);
    endtask : t_idx

    // every register code, the others must stay untouched
    task automatic t_inc;
        logic [63:0] v;
        logic [63:0] x;
        logic [31:0] r;
        for (int k = 0; k < 8; k++) begin
            if (k == 6) continue;
            v = 64'h7f << (8 * k);
            x = 64'h80 << (8 * k);
            setup(v[31:0], v[63:32], 8'h01, 8'h00);
            wr(bla_pkg::OFF_INSTR, {24'h0, 2'b00, 3'(k), 3'b100});
            rd(bla_pkg::OFF_GPR_LO, r);
            chk(r, x[31:0]);
            rd(bla_pkg::OFF_GPR_HI, r);
            chk(r, x[63:32]);
            rd(bla_pkg::OFF_FLAGS, r);
            chk(r & 32'hff, 32'h95);
        end
        setup(32'h0000_ff00, 32'h0, 8'h00, 8'h00);
        run(32'h0000_000c, 8'h00, 8'h50, 8'h00);
        rd(bla_pkg::OFF_GPR_LO, r);
        chk(r, 32'h0000_0000);
    endtask : t_inc

    task automatic t_minc;
        setup(32'h0, 32'h0000_3434, 8'h01, 8'h7f);
        run(32'h0000_0034, 8'h00, 8'h95, 8'h80);
        st(32'h3434_0006);
        setup(32'h0, 32'h0, 8'h00, 8'h82);
        run(32'h0000_0034, 8'h00, 8'h80, 8'h83);
    endtask : t_minc

    // indexed increment is outside the block; unmapped offset refused
    task automatic t_bad;
        logic [31:0] r;
        logic e;
        setup(32'h0, 32'h0, 8'h00, 8'h11);
        run(32'h0000_34dd, 8'h00, 8'h00, 8'h11);
        rd(bla_pkg::OFF_STATUS, r);
        chk(r & 32'h1, 32'h1);
        i_seq.xfer(1'b1, 8'h1c, 32'h5a5a_5a5a, r, e);
        chk({31'h0, e}, 32'h1);
        i_seq.xfer(1'b0, 8'h1c, 32'h0, r, e);
        chk({r[30:0], e}, 32'h1);
    endtask : t_bad

    initial begin
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        t_or();
        t_xor();
        t_cmp();
        t_idx();
        t_inc();
        t_minc();
        t_bad();
        summarize();
    end
endmodule : test_byte_logic_compare_increment_alu
